// ### fdf_defs.vh
// register offsets, reset values, field positions and timing counts
// assumes an 8-bit register port inside the device, one byte per access
`ifndef FDF_DEFS_VH
`define FDF_DEFS_VH

// register offsets
`define FDF_ADDR_DYN1      8'h36
`define FDF_ADDR_DYN2      8'h37
`define FDF_ADDR_MAXD1     8'h38
`define FDF_ADDR_MAXD2     8'h39
`define FDF_ADDR_MAXD3     8'h3a
`define FDF_ADDR_CFG1      8'h40
`define FDF_ADDR_OP1       8'h33
`define FDF_ADDR_OP2       8'h34
`define FDF_ADDR_OP3       8'h35
`define FDF_ADDR_EXT1      8'h76
`define FDF_ADDR_EXT2      8'h77

// reset values
`define FDF_RST_DYN        8'h00
`define FDF_RST_MAXD       8'hff
`define FDF_RST_CFG1       8'h01
`define FDF_RST_OP         8'ha4

// fault codes for an open or shorted diode
`define FDF_FAULT_TWOS     8'h80
`define FDF_FAULT_OFS64    8'h00

// dynamic control 1 fields
`define FDF_B_R2MSB        0
`define FDF_B_UVMODE       1
`define FDF_B_COPY_R1      2
`define FDF_B_COPY_LC      3
`define FDF_B_COPY_R2      4
`define FDF_B_DEN_R1       5
`define FDF_B_DEN_LC       6
`define FDF_B_DEN_R2       7

// main configuration fields
`define FDF_B_RUN          0
`define FDF_B_LOCK         1
`define FDF_B_READY        2
`define FDF_B_ALLMAX       3
`define FDF_B_PWRFLAG      4
`define FDF_B_FIXSPIN      5
`define FDF_B_TIMEOUT      6
`define FDF_B_LATCHRST     7

// interval counts: base decrease count is 8 monitoring cycles
`define FDF_BASE_CYCLES    12'h008
// ready delay after reset, in clock cycles
`define FDF_READY_CYCLES   8'h10

`endif

// ### fdf_interval_ctr.v
// one interval counter per channel, counting monitoring cycles
// assumes mon_tick is a one-cycle pulse per completed monitoring cycle
`timescale 1ns/1ns
`default_nettype none
`include "fdf_defs.vh"

module fdf_interval_ctr (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        mon_tick,   // monitoring cycle done
    input  wire        restart,    // floor just adjusted
    input  wire [11:0] limit,      // cycles to wait
    output reg         expired     // count reached limit
);
    reg [11:0] count_reg;          // cycles since last adjustment

    // count ticks, restart after every adjustment
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 12'h000;
            expired   <= 1'b0;
        end else begin
            if (restart) begin
                count_reg <= 12'h000;
            end else if (mon_tick && count_reg != 12'hfff) begin
                count_reg <= count_reg + 12'h001;
            end
            expired <= (count_reg >= limit) && !restart;
        end
    end
endmodule
`default_nettype wire

// ### fdf_regs.v
// dynamic floor control, undervoltage standby, max duty and main config
// assumes a byte register port from the serial slave, one access a cycle
`timescale 1ns/1ns
`default_nettype none
`include "fdf_defs.vh"

module fdf_regs (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        reg_wr,             // write strobe
    input  wire        reg_rd,             // read strobe
    input  wire [7:0]  reg_addr,           // register offset
    input  wire [7:0]  reg_wdata,          // write data
    output reg  [7:0]  reg_rdata,          // read data
    input  wire        mon_tick,           // monitoring cycle done
    input  wire        twos_format,        // reading format select
    input  wire [23:0] temp_raw,           // three channel readings
    input  wire [2:0]  diode_fault,        // open or shorted diode
    input  wire [23:0] temp_high_lim,      // high limits per channel
    input  wire [23:0] temp_low_lim,       // low limits per channel
    input  wire        core_voltage_low,   // core below low limit
    input  wire        overheat_pin,       // overheat asserted
    input  wire        max_on_overheat,    // overheat uses max duty
    input  wire [23:0] duty_request,       // loop duty per output
    input  wire        variant_latch,      // latching variant
    input  wire        new_reading,        // fresh readings arrive
    output reg  [23:0] temp_report,        // reported readings
    output reg  [23:0] fan_start_temperature, // floor per channel
    output reg  [23:0] duty_out,           // limited duty
    output reg         monitor_run,        // monitoring enabled
    output reg         all_fans_max,       // force max duty
    output reg         fixed_spinup_select,// full spinup timeout
    output reg         bus_timeout_enable, // serial timeout on
    output reg         core_power_report_flag, // power report bit
    output reg         latch_clear,        // clear latched overheat
    output reg         uv_status_set,      // status 1 bit 1 level, held while uv
    output reg         uv_alert,           // alert request
    output reg         hot_mon_enable,     // hot processor monitor
    output reg         shutdown_allow      // shutdown permitted
);
    reg [7:0]  dyn1_reg;       // dynamic floor control 1
    reg [7:0]  dyn2_reg;       // dynamic floor control 2
    reg [23:0] maxd_reg;       // max duty per output
    reg [7:0]  cfg_reg;        // main configuration
    reg [23:0] op_reg;         // operating points
    reg [7:0]  rdy_cnt_reg;    // power-up delay
    reg        freeze_reg;     // readings frozen
    reg [23:0] tsamp_reg;      // held readings
    reg        ovh_d_reg;      // overheat last cycle
    reg [2:0]  step_dir_reg;   // 1 = raise wait active
    reg [2:0]  restart_reg;    // restart interval counters
    wire [2:0] expired;        // interval elapsed
    wire       lock;           // lock state
    wire       uv;             // undervoltage standby active
    wire       wr_ok;          // lockable write allowed
    wire [2:0] code [0:2];     // interval codes
    reg [7:0]  rd_next;        // read mux value
    integer    i;
    integer    j;              // loop index, readings process

    assign lock = cfg_reg[`FDF_B_LOCK];
    assign uv = dyn1_reg[`FDF_B_UVMODE] & core_voltage_low;
    assign wr_ok = reg_wr & ~lock;
    assign code[2] = {dyn1_reg[`FDF_B_R2MSB], dyn2_reg[7:6]};
    assign code[0] = dyn2_reg[2:0];
    assign code[1] = dyn2_reg[5:3];

    // decrease wait in monitoring cycles
    function [11:0] dec_wait;
        input [2:0] n;
        begin
            dec_wait = `FDF_BASE_CYCLES << n;
        end
    endfunction

    // increase wait, twice the decrease wait
    function [11:0] inc_wait;
        input [2:0] n;
        begin
            inc_wait = dec_wait(n) << 1;
        end
    endfunction

    // fault-aware reported byte
    function [7:0] report;
        input [7:0] t;
        input       flt;
        input       twos;
        begin
            if (flt) begin
                report = twos ? `FDF_FAULT_TWOS : `FDF_FAULT_OFS64;
            end else begin
                report = t;
            end
        end
    endfunction

    // interval counters, one per channel
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : chan
            fdf_interval_ctr u_ctr (
                .clk      (clk),
                .rst_b    (rst_b),
                .mon_tick (mon_tick),
                .restart  (restart_reg[g]),
                .limit    (step_dir_reg[g] ? inc_wait(code[g]) :
                           dec_wait(code[g])),
                .expired  (expired[g])
            );
        end
    endgenerate

    // register writes, lock and ready
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dyn1_reg    <= `FDF_RST_DYN;
            dyn2_reg    <= `FDF_RST_DYN;
            maxd_reg    <= {3{`FDF_RST_MAXD}};
            cfg_reg     <= `FDF_RST_CFG1;
            rdy_cnt_reg <= 8'h00;
            latch_clear <= 1'b0;
        end else begin
            latch_clear <= 1'b0;
            if (rdy_cnt_reg != `FDF_READY_CYCLES) begin
                rdy_cnt_reg <= rdy_cnt_reg + 8'h01;
            end else begin
                cfg_reg[`FDF_B_READY] <= 1'b1;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_DYN1) begin
                dyn1_reg <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_DYN2) begin
                dyn2_reg <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_MAXD1) begin
                maxd_reg[7:0] <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_MAXD2) begin
                maxd_reg[15:8] <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_MAXD3) begin
                maxd_reg[23:16] <= reg_wdata;
            end
            if (reg_wr && reg_addr == `FDF_ADDR_CFG1) begin
                cfg_reg[`FDF_B_RUN] <= reg_wdata[`FDF_B_RUN];
                cfg_reg[`FDF_B_ALLMAX] <= reg_wdata[`FDF_B_ALLMAX];
                if (!lock) begin
                    cfg_reg[`FDF_B_LOCK] <= reg_wdata[`FDF_B_LOCK];
                    cfg_reg[`FDF_B_PWRFLAG] <= reg_wdata[`FDF_B_PWRFLAG];
                    cfg_reg[`FDF_B_FIXSPIN] <= reg_wdata[`FDF_B_FIXSPIN];
                    cfg_reg[`FDF_B_TIMEOUT] <= reg_wdata[`FDF_B_TIMEOUT];
                end
                latch_clear <= variant_latch &
                               reg_wdata[`FDF_B_LATCHRST];
            end
        end
    end

    // operating points and dynamic floor adjustment
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_reg                <= {3{`FDF_RST_OP}};
            fan_start_temperature <= 24'h000000;
            step_dir_reg          <= 3'b000;
            restart_reg           <= 3'b000;
            ovh_d_reg             <= 1'b0;
        end else begin
            ovh_d_reg   <= overheat_pin;
            restart_reg <= 3'b000;
            if (wr_ok && reg_addr == `FDF_ADDR_OP1) begin
                op_reg[7:0] <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_OP2) begin
                op_reg[15:8] <= reg_wdata;
            end
            if (wr_ok && reg_addr == `FDF_ADDR_OP3) begin
                op_reg[23:16] <= reg_wdata;
            end
            for (i = 0; i < 3; i = i + 1) begin
                if (overheat_pin && !ovh_d_reg &&
                    dyn1_reg[`FDF_B_COPY_R1 + i]) begin
                    op_reg[i*8 +: 8] <= temp_raw[i*8 +: 8];
                end
                if (dyn1_reg[`FDF_B_DEN_R1 + i] && !uv &&
                    monitor_run && expired[i] && !restart_reg[i]) begin
                    restart_reg[i] <= 1'b1;
                    if (temp_raw[i*8 +: 8] > op_reg[i*8 +: 8] ||
                        temp_raw[i*8 +: 8] > temp_high_lim[i*8 +: 8]) begin
                        if (!step_dir_reg[i] &&
                            fan_start_temperature[i*8 +: 8] != 8'h00) begin
                            fan_start_temperature[i*8 +: 8] <=
                                fan_start_temperature[i*8 +: 8] - 8'h01;
                        end
                        step_dir_reg[i] <= 1'b0;
                    end else if (temp_raw[i*8 +: 8] <
                                 temp_low_lim[i*8 +: 8] ||
                                 temp_raw[i*8 +: 8] <
                                 op_reg[i*8 +: 8]) begin
                        if (step_dir_reg[i] &&
                            fan_start_temperature[i*8 +: 8] != 8'hff) begin
                            fan_start_temperature[i*8 +: 8] <=
                                fan_start_temperature[i*8 +: 8] + 8'h01;
                        end
                        step_dir_reg[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // readings freeze and duty limiting
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freeze_reg  <= 1'b0;
            tsamp_reg   <= 24'h000000;
            temp_report <= 24'h000000;
            duty_out    <= 24'h000000;
        end else begin
            if (reg_rd && (reg_addr == `FDF_ADDR_EXT1 ||
                           reg_addr == `FDF_ADDR_EXT2)) begin
                freeze_reg <= 1'b1;
            end else if (reg_rd && reg_addr >= 8'h25 &&
                         reg_addr <= 8'h27) begin
                freeze_reg <= 1'b0;
            end
            if (new_reading && !freeze_reg) begin
                tsamp_reg <= temp_raw;
            end
            for (j = 0; j < 3; j = j + 1) begin
                temp_report[j*8 +: 8] <= report(tsamp_reg[j*8 +: 8],
                                                 diode_fault[j],
                                                 twos_format);
                if (overheat_pin && !max_on_overheat) begin
                    duty_out[j*8 +: 8] <= 8'hff;
                end else if (overheat_pin || all_fans_max) begin
                    duty_out[j*8 +: 8] <= maxd_reg[j*8 +: 8];
                end else if (!monitor_run) begin
                    duty_out[j*8 +: 8] <= 8'h00;
                end else if (duty_request[j*8 +: 8] >
                             maxd_reg[j*8 +: 8]) begin
                    duty_out[j*8 +: 8] <= maxd_reg[j*8 +: 8];
                end else begin
                    duty_out[j*8 +: 8] <= duty_request[j*8 +: 8];
                end
            end
        end
    end

    // read mux, unmapped reads zero
    always @* begin
        rd_next = 8'h00;
        case (reg_addr)
            `FDF_ADDR_DYN1:  rd_next = dyn1_reg;
            `FDF_ADDR_DYN2:  rd_next = dyn2_reg;
            `FDF_ADDR_MAXD1: rd_next = maxd_reg[7:0];
            `FDF_ADDR_MAXD2: rd_next = maxd_reg[15:8];
            `FDF_ADDR_MAXD3: rd_next = maxd_reg[23:16];
            `FDF_ADDR_CFG1:  rd_next = {1'b0, cfg_reg[6:0]};
            `FDF_ADDR_OP1:   rd_next = op_reg[7:0];
            `FDF_ADDR_OP2:   rd_next = op_reg[15:8];
            `FDF_ADDR_OP3:   rd_next = op_reg[23:16];
            default:         rd_next = 8'h00;
        endcase
    end

    // registered outputs and undervoltage effects
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata              <= 8'h00;
            monitor_run            <= 1'b1;
            all_fans_max           <= 1'b0;
            fixed_spinup_select    <= 1'b0;
            bus_timeout_enable     <= 1'b0;
            core_power_report_flag <= 1'b0;
            uv_status_set          <= 1'b0;
            uv_alert               <= 1'b0;
            hot_mon_enable         <= 1'b1;
            shutdown_allow         <= 1'b1;
        end else begin
            reg_rdata              <= rd_next;
            monitor_run            <= cfg_reg[`FDF_B_RUN];
            all_fans_max           <= cfg_reg[`FDF_B_ALLMAX];
            fixed_spinup_select    <= cfg_reg[`FDF_B_FIXSPIN];
            bus_timeout_enable     <= cfg_reg[`FDF_B_TIMEOUT];
            core_power_report_flag <= cfg_reg[`FDF_B_PWRFLAG];
            uv_status_set          <= uv;
            uv_alert               <= uv;
            hot_mon_enable         <= ~uv;
            shutdown_allow         <= ~uv;
        end
    end
endmodule
`default_nettype wire

// ### fdf_host.sv
// host model: issues byte accesses to the register bank
// assumes strobes are taken on the rising clock edge, data one cycle on
`timescale 1ns/1ns
`default_nettype none
module fdf_host (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write, held through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk) #1;
        reg_wr = 1'b0;
        // released data shows no stale value
        reg_wdata = ~d;
    endtask
    // host read order
    // single reads; an extended read comes before its msb read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ### fdf_regs_monitor.sv
// checker for the floor control register bank
// assumes it is bound to fdf_regs and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module fdf_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        core_voltage_low,
    input wire logic        overheat_pin,
    input wire logic        max_on_overheat,
    input wire logic        variant_latch,
    input wire logic [23:0] duty_request,
    input wire logic [23:0] duty_out,
    input wire logic        monitor_run,
    input wire logic        all_fans_max,
    input wire logic        latch_clear,
    input wire logic        hot_mon_enable,
    input wire logic        shutdown_allow
);
    // one clock domain, reset aborts every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // write-only latch reset top bit of the config reads zero
    property p_bit7;
        reg_addr == 8'h40 |=> !reg_rdata[7];
    endproperty
    a_bit7: assert property (p_bit7) else $error("cfg bit7 set");
    // run and all-max bits follow a config write two cycles on
    property p_cfgw;
        reg_wr && reg_addr == 8'h40 |-> ##2
        (monitor_run == $past(reg_wdata[0], 2) &&
         all_fans_max == $past(reg_wdata[3], 2));
    endproperty
    a_cfgw: assert property (p_cfgw) else $error("cfg bits lost");
    // healthy core voltage keeps hot monitor and shutdown enabled
    property p_uvpair;
        !core_voltage_low |=> hot_mon_enable && shutdown_allow;
    endproperty
    a_uvpair: assert property (p_uvpair) else $error("uv pair");
    // healthy core voltage re-enables the hot monitor
    property p_uvres;
        !core_voltage_low [*2] |-> hot_mon_enable;
    endproperty
    a_uvres: assert property (p_uvres) else $error("uv resume");
    // no latch clear pulse on the plain variant
    property p_latch;
        !variant_latch [*3] |-> !latch_clear;
    endproperty
    a_latch: assert property (p_latch) else $error("latch pulse");
    // overheat with full select forces full scale
    property p_ovh;
        (overheat_pin && !max_on_overheat) [*2] |-> duty_out == 24'hffffff;
    endproperty
    a_ovh: assert property (p_ovh) else $error("overheat duty");
    // monitoring off gives zero duty
    property p_off;
        (!monitor_run && !all_fans_max && !overheat_pin) [*2]
        |-> duty_out == 24'h000000;
    endproperty
    a_off: assert property (p_off) else $error("run off duty");
    // normal control never exceeds the request on output 1
    property p_clamp;
        (monitor_run && !all_fans_max && !overheat_pin) [*2]
        |-> duty_out[7:0] <= $past(duty_request[7:0]);
    endproperty
    a_clamp: assert property (p_clamp) else $error("duty clamp");
endmodule
bind fdf_regs fdf_checker u_chk (.clk(clk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .core_voltage_low(core_voltage_low),
    .overheat_pin(overheat_pin), .max_on_overheat(max_on_overheat),
    .variant_latch(variant_latch), .duty_request(duty_request),
    .duty_out(duty_out), .monitor_run(monitor_run),
    .all_fans_max(all_fans_max), .latch_clear(latch_clear),
    .hot_mon_enable(hot_mon_enable), .shutdown_allow(shutdown_allow));
`default_nettype wire

// ### testbench.sv
// self-checking bench for the floor control register bank
// assumes the host model drives the register port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
 $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk, rst_b, mon_tick, twos_format, core_voltage_low;
    logic        overheat_pin, max_on_overheat, variant_latch, new_reading;
    logic [23:0] temp_raw, temp_high_lim, temp_low_lim, duty_request;
    logic [2:0]  diode_fault;
    logic        reg_wr, reg_rd, monitor_run, all_fans_max, latch_clear;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, q, w;
    logic [23:0] temp_report, fan_start_temperature, duty_out;
    logic        fixed_spinup_select, bus_timeout_enable, uv_alert;
    logic        core_power_report_flag, uv_status_set;
    logic        hot_mon_enable, shutdown_allow;
    logic [7:0]  m [3];     // max duty values written
    int          miscompares, n_tests, n_clr;
    integer      seed;
    fdf_host HOST (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    fdf_regs DUT (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mon_tick(mon_tick),
        .twos_format(twos_format), .temp_raw(temp_raw),
        .diode_fault(diode_fault), .temp_high_lim(temp_high_lim),
        .temp_low_lim(temp_low_lim), .core_voltage_low(core_voltage_low),
        .overheat_pin(overheat_pin), .max_on_overheat(max_on_overheat),
        .duty_request(duty_request), .variant_latch(variant_latch),
        .new_reading(new_reading), .temp_report(temp_report),
        .fan_start_temperature(fan_start_temperature),
        .duty_out(duty_out), .monitor_run(monitor_run),
        .all_fans_max(all_fans_max),
        .fixed_spinup_select(fixed_spinup_select),
        .bus_timeout_enable(bus_timeout_enable),
        .core_power_report_flag(core_power_report_flag),
        .latch_clear(latch_clear), .uv_status_set(uv_status_set),
        .uv_alert(uv_alert), .hot_mon_enable(hot_mon_enable),
        .shutdown_allow(shutdown_allow));
    // free running clock, 8 ns period
    always #4 clk = ~clk;
    // counts latch clear pulses
    always @(posedge clk) if (latch_clear === 1'b1) n_clr++;
    // expected limited duty
    function automatic logic [7:0] emin(input logic [7:0] a, b);
        return (a < b) ? a : b;
    endfunction
    // expected fault code for the reading format
    function automatic logic [7:0] efault(input logic tw);
        return tw ? 8'h80 : 8'h00;
    endfunction
    // wait n edges, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // n monitoring cycles, one tick every other clock
    task automatic ticks(input int n);
        repeat (n) begin
            mon_tick = 1'b1;
            cyc(1);
            mon_tick = 1'b0;
            cyc(1);
        end
    endtask
    // fresh readings strobe
    task automatic pulse_new;
        new_reading = 1'b1;
        cyc(1);
        new_reading = 1'b0;
        cyc(3);
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #(20000 * 8);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
    // main sequence
    initial begin
        seed = 32'hbf849a46;
        {clk, rst_b, mon_tick, twos_format, core_voltage_low} = '0;
        {overheat_pin, max_on_overheat, variant_latch, new_reading} = '0;
        {temp_raw, temp_low_lim, duty_request, diode_fault} = '0;
        temp_high_lim = 24'hffffff;
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        HOST.rd(8'h40, d); `CHK(d, 8'h01)
        HOST.rd(8'h3a, d); `CHK(d, 8'hff)
        HOST.rd(8'h37, d); `CHK(d, 8'h00)
        HOST.wr(8'h00, 8'h5a);
        HOST.rd(8'h00, d); `CHK(d, 8'h00)
        cyc(20);
        HOST.rd(8'h40, d); `CHK(d, 8'h05)
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            q = 8'(8'h36 + i % 5);
            w = (i == 0) ? 8'hff : 8'($random(seed));
            HOST.wr(q, w);
            HOST.rd(q, d); `CHK(d, w)
        end
        $display("readback test done");
        HOST.wr(8'h36, 8'h04);
        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 3; k++) begin
                m[k] = (i == 0) ? 8'h00 : 8'($random(seed));
                HOST.wr(8'(8'h38 + k), m[k]);
            end
            duty_request = (i == 1) ? 24'hffffff : 24'($random(seed));
            cyc(3);
            for (int k = 0; k < 3; k++)
                `CHK(duty_out[k*8+:8], emin(duty_request[k*8+:8], m[k]))
        end
        HOST.wr(8'h40, 8'h09);
        cyc(3);
        for (int k = 0; k < 3; k++) `CHK(duty_out[k*8+:8], m[k])
        temp_raw = 24'($random(seed)) | 24'h808080;
        pulse_new();
        max_on_overheat = 1'b1;
        overheat_pin = 1'b1;
        cyc(3);
        for (int k = 0; k < 3; k++) `CHK(duty_out[k*8+:8], m[k])
        max_on_overheat = 1'b0;
        cyc(3);
        `CHK(duty_out, 24'hffffff)
        HOST.rd(8'h33, d); `CHK(d, temp_raw[7:0])
        HOST.rd(8'h34, d); `CHK(d, 8'ha4)
        overheat_pin = 1'b0;
        HOST.wr(8'h40, 8'h00);
        cyc(3);
        `CHK(duty_out, 24'h000000)
        $display("duty test done");
        for (int t = 0; t < 2; t++) begin
            twos_format = t[0];
            diode_fault = 3'b001;
            pulse_new();
            `CHK(temp_report[7:0], efault(t[0]))
            `CHK(temp_report[15:8], temp_raw[15:8])
        end
        diode_fault = 3'b000;
        HOST.rd(8'h76, d);
        q = temp_report[23:16];
        temp_raw[23:16] = ~q;
        pulse_new();
        `CHK(temp_report[23:16], q)
        HOST.rd(8'h27, d);
        pulse_new();
        `CHK(temp_report[23:16], ~q)
        $display("fault test done");
        temp_raw[7:0] = 8'h10;
        temp_low_lim[7:0] = 8'h20;
        pulse_new();
        HOST.wr(8'h40, 8'h01);
        HOST.wr(8'h37, 8'h01);
        HOST.wr(8'h36, 8'h00);
        q = fan_start_temperature[7:0];
        ticks(40);
        `CHK(fan_start_temperature[7:0], q)
        core_voltage_low = 1'b1;
        HOST.wr(8'h36, 8'h22);
        ticks(40);
        `CHK(hot_mon_enable, 1'b0)
        `CHK(shutdown_allow, 1'b0)
        `CHK(fan_start_temperature[7:0], q)
        core_voltage_low = 1'b0;
        cyc(3);
        `CHK(hot_mon_enable, 1'b1)
        ticks(31);
        `CHK(fan_start_temperature[7:0], q)
        ticks(1);
        cyc(1);
        `CHK(fan_start_temperature[7:0], 8'(q + 8'h01))
        $display("floor test done");
        HOST.wr(8'h40, 8'h81);
        cyc(3);
        `CHK(n_clr, 0)
        variant_latch = 1'b1;
        HOST.wr(8'h40, 8'h81);
        cyc(3);
        `CHK(n_clr, 1)
        HOST.rd(8'h40, d); `CHK(d, 8'h05)
        $display("latch test done");
        HOST.wr(8'h40, 8'h73);
        HOST.rd(8'h40, d); `CHK(d, 8'h77)
        cyc(2);
        `CHK(bus_timeout_enable, 1'b1)
        `CHK(fixed_spinup_select, 1'b1)
        `CHK(core_power_report_flag, 1'b1)
        HOST.wr(8'h40, 8'h08);
        HOST.rd(8'h40, d); `CHK(d, 8'h7e)
        for (int k = 0; k < 5; k++) begin
            HOST.rd(8'(8'h36 + k), q);
            HOST.wr(8'(8'h36 + k), ~q);
            HOST.rd(8'(8'h36 + k), d); `CHK(d, q)
        end
        `CHK(all_fans_max, 1'b1)
        `CHK(monitor_run, 1'b0)
        $display("lock test done");
        finish_test();
    end
endmodule
`default_nettype wire
